// ---- afi_host_model.sv ----
`timescale 1ns/1ps
module afi_host_model
    import afi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        irq,
    output logic [15:0]      rise_count,
    output logic [15:0]      last_width
);
    logic        irq_reg;
    logic [15:0] run_reg;

    // Host only times the pin; register traffic comes from the bench
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_reg    <= 1'b0;
            run_reg    <= 16'h0;
            rise_count <= 16'h0;
            last_width <= 16'h0;
        end
        else
        begin
            irq_reg <= irq;
            run_reg <= irq ? run_reg + 16'h1 : 16'h0;
            if (irq && !irq_reg)
                rise_count <= rise_count + 16'h1;
            if (!irq && irq_reg)
                last_width <= run_reg;
        end
    end
endmodule : afi_host_model

// ---- afi_irq_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Indication style field in bits 7-6 of config register, resets zero.
// - Style zero: one active-high 2 ms pulse per interrupt.
// - Style one: 2 ms pulses every 4 ms while any flag is set.
// - Style two: output held high until flags are cleared.
// - Source-enable bits reset zero; one lets source raise interrupts.
// - Enable bits 7..4: over-current, undervolt, clock error 2, overtemp.
// - Enable bits 3..0: brownout, clock error 1, modulator, word-clock halt.
// - First detect register read-only, resets zero, read returns then clears.
// - Flags set on condition and stay set until next register read.
// - First flags 7..4: over-current, undervolt, clock error 1, overtemp.
// - First flags 3..1: brownout, clock error 2, conversion done; 0 zero.
// - Second detect register holds word-clock and modulator halt flags.
// - Indication reaches the pin only when pin function selects interrupt.
module afi_irq_ctrl
    import afi_pkg::*;
#(
    parameter int PULSE_CYC  = AFI_PULSE_CYC,
    parameter int PERIOD_CYC = AFI_PERIOD_CYC
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire afi_reg_req_t reg_req,
    output logic [7:0]        reg_rdata,
    output logic              reg_rvalid,
    input  wire afi_events_t  events,
    input  wire logic [2:0]   pin_function,
    output logic              irq_out
);

    logic [7:0]  ind_cfg_reg;
    logic [7:0]  src_en_reg;
    logic [7:0]  flags_one_reg;
    logic [7:0]  flags_two_reg;
    logic [7:0]  flags_one_next;
    logic [7:0]  flags_two_next;
    logic [7:0]  set_one;
    logic [7:0]  set_two;
    logic [7:0]  en_one;
    logic [7:0]  en_two;
    logic [7:0]  rdata_next;
    logic        rd_one;
    logic        rd_two;
    logic        trigger;
    logic        pending;
    logic        indicate;
    afi_events_t ev_meta_reg;
    afi_events_t ev_sync_reg;

    function automatic logic hit(input afi_reg_req_t r,
                                 input logic [7:0] a);
        hit = (r.addr == a);
    endfunction : hit

    // Fault detectors sit outside this clock domain
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ev_meta_reg <= '0;
            ev_sync_reg <= '0;
        end
        else if (ce)
        begin
            ev_meta_reg <= events;
            ev_sync_reg <= ev_meta_reg;
        end
    end

    always_comb
    begin
        set_one = AFI_RESET_BYTE;
        set_two = AFI_RESET_BYTE;
        set_one[AFI_F1_OVRCUR] = ev_sync_reg.overcurrent;
        set_one[AFI_F1_AUV]    = ev_sync_reg.analog_undervolt;
        set_one[AFI_F1_CLKE1]  = ev_sync_reg.clock_error_one;
        set_one[AFI_F1_OVRTMP] = ev_sync_reg.overtemp;
        set_one[AFI_F1_BRNOUT] = ev_sync_reg.brownout;
        set_one[AFI_F1_CLKE2]  = ev_sync_reg.clock_error_two;
        set_one[AFI_F1_SAR]    = ev_sync_reg.conversion_done;
        set_two[AFI_F2_WCKHLT] = ev_sync_reg.word_clock_halt;
        set_two[AFI_F2_MODHLT] = ev_sync_reg.modulator_halt;
    end

    // Enable mask mapped onto flag positions
    always_comb
    begin
        en_one = AFI_RESET_BYTE;
        en_two = AFI_RESET_BYTE;
        en_one[AFI_F1_OVRCUR] = src_en_reg[AFI_EN_OVRCUR];
        en_one[AFI_F1_AUV]    = src_en_reg[AFI_EN_AUV];
        en_one[AFI_F1_CLKE2]  = src_en_reg[AFI_EN_CLKE2];
        en_one[AFI_F1_OVRTMP] = src_en_reg[AFI_EN_OVRTMP];
        en_one[AFI_F1_BRNOUT] = src_en_reg[AFI_EN_BRNOUT];
        en_one[AFI_F1_CLKE1]  = src_en_reg[AFI_EN_CLKE1];
        en_two[AFI_F2_MODHLT] = src_en_reg[AFI_EN_MODHLT];
        en_two[AFI_F2_WCKHLT] = src_en_reg[AFI_EN_WCKHLT];
    end

    assign rd_one = reg_req.rd && hit(reg_req, AFI_ADDR_FLAGS_ONE);
    assign rd_two = reg_req.rd && hit(reg_req, AFI_ADDR_FLAGS_TWO);

    // A new event in the read cycle survives the clear
    always_comb
    begin
        flags_one_next = (rd_one ? AFI_RESET_BYTE : flags_one_reg)
                         | set_one;
        flags_two_next = (rd_two ? AFI_RESET_BYTE : flags_two_reg)
                         | set_two;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_one_reg <= AFI_RESET_BYTE;
            flags_two_reg <= AFI_RESET_BYTE;
        end
        else if (ce)
        begin
            flags_one_reg <= flags_one_next;
            flags_two_reg <= flags_two_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ind_cfg_reg <= AFI_RESET_BYTE;
            src_en_reg  <= AFI_RESET_BYTE;
        end
        else if (ce && reg_req.wr)
        begin
            if (hit(reg_req, AFI_ADDR_IND_CFG))
                ind_cfg_reg <= reg_req.wdata;
            else if (hit(reg_req, AFI_ADDR_SRC_EN))
                src_en_reg <= reg_req.wdata;
        end
    end

    always_comb
    begin
        if (hit(reg_req, AFI_ADDR_IND_CFG))
            rdata_next = ind_cfg_reg;
        else if (hit(reg_req, AFI_ADDR_SRC_EN))
            rdata_next = src_en_reg;
        else if (hit(reg_req, AFI_ADDR_FLAGS_ONE))
            rdata_next = flags_one_reg;
        else if (hit(reg_req, AFI_ADDR_FLAGS_TWO))
            rdata_next = flags_two_reg;
        else
            rdata_next = AFI_RESET_BYTE;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata  <= AFI_RESET_BYTE;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd)
                reg_rdata <= rdata_next;
        end
    end

    // Rising edge of any enabled flag, judged on the next flag bits against the stored ones
    assign trigger = |(((flags_one_next & ~flags_one_reg) & en_one) |
                       ((flags_two_next & ~flags_two_reg) & en_two));
    // Any sticky flag holds the train or level, enabled or not
    assign pending = |flags_one_reg || |flags_two_reg;

    afi_pulse_gen #(
        .PULSE_CYC  (PULSE_CYC),
        .PERIOD_CYC (PERIOD_CYC)
    ) u_pulse (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .trigger (ce && trigger),
        .pending (pending),
        .style   (ind_cfg_reg[AFI_STYLE_HI:AFI_STYLE_LO]),
        .level   (indicate)
    );

    assign irq_out = indicate && (pin_function == AFI_PIN_FN_IRQ);

    chk_pin_gate: assert property (@(posedge clk) disable iff (!arst_n)
        pin_function != AFI_PIN_FN_IRQ |-> !irq_out)
        else $error("interrupt drives pin outside interrupt function");

    chk_read_clears: assert property (@(posedge clk) disable iff (!arst_n)
        ce && rd_one && set_one == AFI_RESET_BYTE |=>
            flags_one_reg == AFI_RESET_BYTE)
        else $error("first flags not cleared by read");

    chk_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !rd_one |=> (flags_one_reg & $past(flags_one_reg))
            == $past(flags_one_reg))
        else $error("first flag dropped without read");

    chk_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
        ce && ev_sync_reg.word_clock_halt |=> flags_two_reg[AFI_F2_WCKHLT])
        else $error("word clock halt flag lost");

    chk_bit0_zero: assert property (@(posedge clk) disable iff (!arst_n)
        !flags_one_reg[0])
        else $error("reserved flag bit set");

    chk_disabled_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        ce && src_en_reg == AFI_RESET_BYTE |-> !trigger)
        else $error("disabled source raised an interrupt");

endmodule : afi_irq_ctrl

// ---- afi_pkg.sv ----
package afi_pkg;

    localparam logic [7:0] AFI_ADDR_IND_CFG   = 8'h24;
    localparam logic [7:0] AFI_ADDR_SRC_EN    = 8'h25;
    localparam logic [7:0] AFI_ADDR_FLAGS_ONE = 8'h26;
    localparam logic [7:0] AFI_ADDR_FLAGS_TWO = 8'h27;

    localparam logic [7:0] AFI_RESET_BYTE     = 8'h00;
    localparam logic [1:0] AFI_STYLE_RESET    = 2'h0;
    localparam logic [2:0] AFI_PIN_FN_IRQ     = 3'h1;

    localparam int AFI_STYLE_HI = 7;
    localparam int AFI_STYLE_LO = 6;

    localparam logic [1:0] AFI_STYLE_SINGLE = 2'h0;
    localparam logic [1:0] AFI_STYLE_REPEAT = 2'h1;
    localparam logic [1:0] AFI_STYLE_LEVEL  = 2'h2;

    // Enable register bit positions
    localparam int AFI_EN_OVRCUR  = 7;
    localparam int AFI_EN_AUV     = 6;
    localparam int AFI_EN_CLKE2   = 5;
    localparam int AFI_EN_OVRTMP  = 4;
    localparam int AFI_EN_BRNOUT  = 3;
    localparam int AFI_EN_CLKE1   = 2;
    localparam int AFI_EN_MODHLT  = 1;
    localparam int AFI_EN_WCKHLT  = 0;

    // First flag register bit positions
    localparam int AFI_F1_OVRCUR  = 7;
    localparam int AFI_F1_AUV     = 6;
    localparam int AFI_F1_CLKE1   = 5;
    localparam int AFI_F1_OVRTMP  = 4;
    localparam int AFI_F1_BRNOUT  = 3;
    localparam int AFI_F1_CLKE2   = 2;
    localparam int AFI_F1_SAR     = 1;

    // Second flag register bit positions
    localparam int AFI_F2_WCKHLT  = 7;
    localparam int AFI_F2_MODHLT  = 6;

    localparam int AFI_CLK_HZ     = 40_000_000;
    localparam int AFI_PULSE_MS   = 2;
    localparam int AFI_PERIOD_MS  = 4;
    localparam int AFI_PULSE_CYC  = AFI_CLK_HZ / 1000 * AFI_PULSE_MS;
    localparam int AFI_PERIOD_CYC = AFI_CLK_HZ / 1000 * AFI_PERIOD_MS;
    localparam int AFI_CNT_W      = 18;

    typedef struct packed {
        logic overcurrent;
        logic analog_undervolt;
        logic overtemp;
        logic brownout;
        logic clock_error_one;
        logic clock_error_two;
        logic conversion_done;
        logic modulator_halt;
        logic word_clock_halt;
    } afi_events_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afi_reg_req_t;

endpackage : afi_pkg

// ---- afi_pulse_gen.sv ----
`timescale 1ns/1ps
module afi_pulse_gen
    import afi_pkg::*;
#(
    parameter int PULSE_CYC  = AFI_PULSE_CYC,
    parameter int PERIOD_CYC = AFI_PERIOD_CYC
)
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       trigger,
    input  wire logic       pending,
    input  wire logic [1:0] style,
    output logic            level
);

    localparam logic [AFI_CNT_W-1:0] PULSE_LAST =
        AFI_CNT_W'(PULSE_CYC - 1);
    localparam logic [AFI_CNT_W-1:0] PERIOD_LAST =
        AFI_CNT_W'(PERIOD_CYC - 1);
    localparam logic [AFI_CNT_W-1:0] CNT_ZERO = '0;

    typedef enum logic [1:0] {AFI_IDLE, AFI_SINGLE, AFI_REPEAT, AFI_HOLD}
        afi_state_t;

    afi_state_t             state_reg;
    logic [AFI_CNT_W-1:0]   cnt_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= AFI_IDLE;
            cnt_reg   <= CNT_ZERO;
        end
        else if (ce)
        begin
            case (state_reg)
                AFI_IDLE:
                begin
                    cnt_reg <= CNT_ZERO;
                    if (trigger)
                    begin
                        if (style == AFI_STYLE_SINGLE)
                            state_reg <= AFI_SINGLE;
                        else if (style == AFI_STYLE_REPEAT)
                            state_reg <= AFI_REPEAT;
                        else if (style == AFI_STYLE_LEVEL)
                            state_reg <= AFI_HOLD;
                    end
                end
                AFI_SINGLE:
                begin
                    // Exactly one pulse, later triggers ignored meanwhile
                    if (cnt_reg == PULSE_LAST)
                        state_reg <= AFI_IDLE;
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                AFI_REPEAT:
                begin
                    // Train ends only at a period boundary
                    if (cnt_reg == PERIOD_LAST)
                    begin
                        cnt_reg <= CNT_ZERO;
                        if (!pending)
                            state_reg <= AFI_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                default:
                begin
                    if (!pending)
                        state_reg <= AFI_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        case (state_reg)
            AFI_SINGLE: level = 1'b1;
            AFI_REPEAT: level = (cnt_reg <= PULSE_LAST);
            AFI_HOLD:   level = 1'b1;
            default:    level = 1'b0;
        endcase
    end

    sequence single_start_seq;
        $rose(state_reg == AFI_SINGLE) && ce;
    endsequence

    sequence single_run_seq;
        (state_reg == AFI_SINGLE) [*8];
    endsequence

    chk_single_width: assert property (@(posedge clk) disable iff (!arst_n)
        single_start_seq |-> single_run_seq)
        else $error("single pulse ended early");

    chk_hold_release: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == AFI_HOLD && !pending && ce |=>
            state_reg == AFI_IDLE)
        else $error("held level did not drop after clear");

endmodule : afi_pulse_gen

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (g), (e)); end end
module tb;
    import afi_pkg::*;
    localparam int PULSE  = 8;
    localparam int PERIOD = 16;
    localparam int LIMIT  = 8000;

    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         ce = 1'b1;
    logic [2:0]   pin_function = 3'h1;
    afi_reg_req_t reg_req = '0;
    afi_events_t  events = '0;
    logic [7:0]   reg_rdata;
    logic         reg_rvalid;
    logic         irq_out;
    logic [15:0]  rise_count;
    logic [15:0]  last_width;
    logic [15:0]  rc;
    int           mismatches = 0;
    int           samples_checked = 0;
    int           cycles = 0;
    // Index order follows the event struct from its LSB upwards
    logic [7:0]   f1_t [9] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h20,
                               8'h08, 8'h10, 8'h40, 8'h80};
    logic [7:0]   f2_t [9] = '{8'h80, 8'h40, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]   en_t [9] = '{8'h01, 8'h02, 8'h00, 8'h20, 8'h04,
                               8'h08, 8'h10, 8'h40, 8'h80};

    always #12.5 clk = ~clk;

    afi_irq_ctrl #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) uut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .events(events),
        .pin_function(pin_function), .irq_out(irq_out));

    afi_host_model host (
        .clk(clk), .arst_n(arst_n), .irq(irq_out),
        .rise_count(rise_count), .last_width(last_width));

    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = d;
        cyc(1);
        reg_req.wr = 1'b0;
        cyc(1);
    endtask : wr

    // Extra idle cycle keeps the strobe from toggling twice in one step
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        cyc(1);
        reg_req.rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
        cyc(1);
        `CHK(reg_rvalid, 1'b0)
    endtask : rdc

    task automatic clr();
        reg_req.rd   = 1'b1;
        reg_req.addr = AFI_ADDR_FLAGS_ONE;
        cyc(1);
        reg_req.addr = AFI_ADDR_FLAGS_TWO;
        cyc(1);
        reg_req.rd = 1'b0;
        cyc(1);
    endtask : clr

    task automatic fire(input int i);
        events = afi_events_t'(9'h001 << i);
        cyc(2);
        events = '0;
        cyc(5);
    endtask : fire

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        rdc(AFI_ADDR_IND_CFG, 8'h00);
        rdc(AFI_ADDR_SRC_EN, 8'h00);
        rdc(AFI_ADDR_FLAGS_ONE, 8'h00);
        rdc(AFI_ADDR_FLAGS_TWO, 8'h00);
        rdc(8'h30, 8'h00);
        wr(AFI_ADDR_IND_CFG, 8'hff);
        rdc(AFI_ADDR_IND_CFG, 8'hff);
        wr(AFI_ADDR_SRC_EN, 8'ha5);
        rdc(AFI_ADDR_SRC_EN, 8'ha5);
        wr(AFI_ADDR_FLAGS_ONE, 8'hff);
        rdc(AFI_ADDR_FLAGS_ONE, 8'h00);
        wr(AFI_ADDR_IND_CFG, 8'h80);
        for (int i = 0; i < 9; i++)
        begin
            wr(AFI_ADDR_SRC_EN, ~en_t[i]);
            fire(i);
            `CHK(irq_out, 1'b0)
            rdc(AFI_ADDR_FLAGS_ONE, f1_t[i]);
            rdc(AFI_ADDR_FLAGS_TWO, f2_t[i]);
            rdc(AFI_ADDR_FLAGS_ONE, 8'h00);
            wr(AFI_ADDR_SRC_EN, en_t[i]);
            fire(i);
            `CHK(irq_out, (en_t[i] != 8'h00))
            cyc(3);
            `CHK(irq_out, (en_t[i] != 8'h00))
            clr();
            cyc(2);
            `CHK(irq_out, 1'b0)
        end
        pin_function = 3'h0;
        wr(AFI_ADDR_SRC_EN, 8'h08);
        fire(5);
        `CHK(irq_out, 1'b0)
        pin_function = 3'h1;
        cyc(1);
        `CHK(irq_out, 1'b1)
        clr();
        cyc(2);
        wr(AFI_ADDR_IND_CFG, 8'hc0);
        fire(5);
        `CHK(irq_out, 1'b0)
        ce = 1'b0;
        wr(AFI_ADDR_SRC_EN, 8'h00);
        ce = 1'b1;
        rdc(AFI_ADDR_SRC_EN, 8'h08);
        clr();
        wr(AFI_ADDR_IND_CFG, 8'h00);
        rc = rise_count;
        fire(5);
        cyc(30);
        `CHK(rise_count - rc, 16'h1)
        `CHK(last_width, 16'(PULSE))
        clr();
        wr(AFI_ADDR_IND_CFG, 8'h40);
        rc = rise_count;
        fire(5);
        cyc(4 * PERIOD);
        `CHK(rise_count - rc, 16'h5)
        `CHK(last_width, 16'(PULSE))
        clr();
        cyc(2 * PERIOD);
        rc = rise_count;
        cyc(2 * PERIOD);
        `CHK(rise_count, rc)
        `CHK(irq_out, 1'b0)
        conclude();
    end
endmodule : tb
